/* File: scc_bridge_model.sv */
module scc_bridge_model (
	input  wire logic       clk,
	input  wire logic       hs_a,
	input  wire logic       ls_a,
	input  wire logic       hs_b,
	input  wire logic       ls_b,
	input  wire logic [7:0] trip_level,
	input  wire logic       stall,
	output logic            trip_cmp = 1'b0,
	output logic            valley_cmp = 1'b0
);
	// ------------------------------------------------------------------
	// Winding current, four units per trip step
	// ------------------------------------------------------------------
	int cur = 0;

	// Stall holds recirculating current, to keep the trip comparator up
	always @(posedge clk) begin
		if (hs_a && ls_b)
			cur = cur + 4;
		else if (hs_b && ls_a)
			cur = (cur > 3) ? cur - 3 : 0;
		else if (ls_a && ls_b && !stall && cur > 0)
			cur = cur - 1;
		else if (!ls_a && !ls_b)
			cur = 0;
		trip_cmp   <= cur >= 4 * int'(trip_level);
		valley_cmp <= cur < 4 * int'(trip_level) - 40;
	end
endmodule

/* File: scc_chopper.sv */
// Function
// R01 - Drive to trip, decay off time, redrive
// R02 - Fast decay reverses the bridge
// R03 - Slow decay turns both low sides on
// R04 - Second select Hi-Z forces dynamic decay
// R05 - Decay selection applied after 10 us deglitch
// R06 - Decode decay pins into six schemes
// R07 - Slow-mixed: slow rising, mixed falling steps
// R08 - Coarse stepping always uses falling scheme (code applies this to slow-mixed only; dynamic still uses fall_pending)
// R09 - Slow decay extends while above trip
// R10 - Mixed decay: fast part then slow
// R11 - Dynamic decay retunes fast share each cycle
// R12 - Dynamic decay uses fast on falling steps
// R13 - Ripple control: slow until valley reached
// R14 - Off-time pin selects ripple in ripple mode
// R15 - Off-time pin selects decay interval otherwise
// R16 - Off-time change applied after 10 us deglitch
// R17 - Comparator blanked 1 us at drive start
// R18 - Comparators synchronous; step sense from magnitude
// R19 - Multi-level pins arrive as decoded codes
//
// Added by the designer: the address map and the Avalon-MM slave port.
module scc_chopper (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	input  wire logic [1:0]  decay_select_a,
	input  wire logic [1:0]  decay_select_b,
	input  wire logic [1:0]  off_time_select,
	input  wire logic [7:0]  trip_current_level,
	input  wire logic        winding_dir,
	input  wire logic        trip_cmp,
	input  wire logic        valley_cmp,
	output logic             hs_a,
	output logic             ls_a,
	output logic             hs_b,
	output logic             ls_b,
	output logic [1:0]       valley_current_level,
	input  wire logic [1:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest
);

	typedef enum logic [2:0] {
		SCC_ST_OFF,
		SCC_ST_BLANK,
		SCC_ST_DRIVE,
		SCC_ST_FAST,
		SCC_ST_SLOW,
		SCC_ST_VALLEY
	} scc_state_e;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Pin pair to scheme; Hi-Z on the second select wins
	function automatic scc_pkg::scc_scheme_e decode_decay(
		input logic [1:0] a,
		input logic [1:0] b
	);
		logic a_mid;
		logic b_high;
		a_mid  = (a == scc_pkg::PIN_HIZ) || (a == scc_pkg::PIN_RES); // R19
		b_high = (b == scc_pkg::PIN_HIGH);
		if (b == scc_pkg::PIN_HIZ || b == scc_pkg::PIN_RES) begin
			return scc_pkg::SCC_DYNAMIC; // R04
		end else if (a_mid) begin
			return b_high ? scc_pkg::SCC_SLOW : scc_pkg::SCC_MIX60; // R06
		end else if (a == scc_pkg::PIN_HIGH) begin
			return b_high ? scc_pkg::SCC_SLOWMIX : scc_pkg::SCC_MIX30; // R06
		end else begin
			return b_high ? scc_pkg::SCC_RIPPLE : scc_pkg::SCC_DYNAMIC; // R06
		end
	endfunction

	// Off-time pin code to decay interval in cycles
	function automatic logic [scc_pkg::TW-1:0] off_time_select_cycles(
		input logic [1:0] code
	);
		case (code)
			scc_pkg::PIN_LOW:  return scc_pkg::OFF_TIME_SELECT_0_CYC; // R15
			scc_pkg::PIN_HIGH: return scc_pkg::OFF_TIME_SELECT_1_CYC;
			scc_pkg::PIN_HIZ:  return scc_pkg::OFF_TIME_SELECT_Z_CYC;
			default:           return scc_pkg::OFF_TIME_SELECT_R_CYC;
		endcase
	endfunction

	// Share of an interval, truncated; 17 bits hold the product
	function automatic logic [scc_pkg::TW-1:0] share_of(
		input logic [scc_pkg::TW-1:0] len,
		input logic [6:0]             pct
	);
		logic [16:0] prod;
		prod = 17'(len) * 17'(pct);
		return scc_pkg::TW'(prod / 17'd100);
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	scc_state_e                state;
	scc_state_e                next_state;
	scc_pkg::scc_scheme_e      scheme_app;
	scc_pkg::scc_scheme_e      scheme_cand;
	logic [1:0]                off_time_select_app;
	logic [1:0]                off_time_select_cand;
	logic [scc_pkg::TW-1:0]    dg_decay_cnt;
	logic [scc_pkg::TW-1:0]    dg_off_time_select_cnt;
	logic [scc_pkg::TW-1:0]    timer;
	logic [scc_pkg::TW-1:0]    next_timer;
	logic [scc_pkg::TW-1:0]    fast_len;
	logic [scc_pkg::TW-1:0]    next_fast_len;
	logic [2:0]                dyn_share;
	logic [2:0]                next_dyn_share;
	logic [7:0]                last_level;
	logic                      step_inc;
	logic                      fall_pending;
	logic                      slow_extend;
	logic                      next_slow_extend;
	logic                      overshoot;
	logic [1:0]                ctrl;
	logic                      bus_ack;

	// ------------------------------------------------------------------
	// Decode and selection
	// ------------------------------------------------------------------
	wire scc_pkg::scc_scheme_e scheme_raw = decode_decay(decay_select_a,
		decay_select_b);
	wire logic [scc_pkg::TW-1:0] off_time_select_len = off_time_select_cycles(off_time_select_app);
	wire logic run    = ctrl[scc_pkg::CTRL_ENABLE];
	wire logic coarse = ctrl[scc_pkg::CTRL_COARSE];
	wire logic rising = step_inc && !coarse; // R08
	wire logic level_up   = trip_current_level > last_level; // R18
	wire logic level_down = trip_current_level < last_level;
	wire logic off_time_select_end   = (timer >= off_time_select_len - scc_pkg::TW'(1));
	wire logic blank_end  = (timer >= scc_pkg::BLANK_CYC - scc_pkg::TW'(1));
	wire logic long_drive = (timer >= off_time_select_len); // R11
	wire logic [6:0] dyn_pct = 7'(dyn_share) * scc_pkg::PCT_DYN_STEP;

	// Fast part of the coming decay, by effective scheme
	logic [6:0] fast_pct;
	always_comb begin
		fast_pct = 7'h00;
		case (scheme_app)
			scc_pkg::SCC_MIX30:   fast_pct = scc_pkg::PCT_MIX30;
			scc_pkg::SCC_MIX60:   fast_pct = scc_pkg::PCT_MIX60;
			scc_pkg::SCC_SLOWMIX: fast_pct = rising ? 7'h00 :
				scc_pkg::PCT_MIX30; // R07
			scc_pkg::SCC_DYNAMIC: fast_pct = fall_pending ?
				scc_pkg::PCT_FULL : dyn_pct; // R12
			default:              fast_pct = 7'h00;
		endcase
	end

	// ------------------------------------------------------------------
	// Chopping sequence
	// ------------------------------------------------------------------
	// Timer is shared: blank, drive length and decay interval
	always_comb begin
		next_state       = state;
		next_timer       = timer + scc_pkg::TW'(1);
		next_fast_len    = fast_len;
		next_dyn_share   = dyn_share;
		next_slow_extend = slow_extend;
		case (state)
			SCC_ST_OFF: begin
				next_timer = '0;
				if (run) begin
					next_state = SCC_ST_BLANK;
				end
			end
			SCC_ST_BLANK: begin
				if (blank_end) begin
					next_state = SCC_ST_DRIVE; // R17
				end
			end
			SCC_ST_DRIVE: begin
				if (long_drive && dyn_share != 3'h0 && timer == off_time_select_len) begin
					next_dyn_share = dyn_share - 3'h1; // R11
				end
				if (trip_cmp) begin
					next_timer    = '0; // R01
					next_fast_len = share_of(off_time_select_len, fast_pct); // R10
					next_slow_extend = (scheme_app == scc_pkg::SCC_SLOW) ||
						(scheme_app == scc_pkg::SCC_SLOWMIX && rising);
					if (overshoot && dyn_share != scc_pkg::DYN_SHARE_MAX) begin
						next_dyn_share = dyn_share + 3'h1; // R11
					end
					if (scheme_app == scc_pkg::SCC_RIPPLE) begin
						next_state = SCC_ST_VALLEY; // R13
					end else if (fast_pct != 7'h00) begin
						next_state = SCC_ST_FAST;
					end else begin
						next_state = SCC_ST_SLOW;
					end
				end
			end
			SCC_ST_FAST: begin
				if (off_time_select_end) begin
					next_timer = '0;
					next_state = SCC_ST_BLANK; // R01
				end else if (timer >= fast_len - scc_pkg::TW'(1)) begin
					next_state = SCC_ST_SLOW; // R10
				end
			end
			SCC_ST_SLOW: begin
				if (off_time_select_end) begin
					next_timer = '0;
					if (!(slow_extend && trip_cmp)) begin
						next_state = SCC_ST_BLANK; // R09
					end
				end
			end
			SCC_ST_VALLEY: begin
				next_timer = '0;
				if (valley_cmp) begin
					next_state = SCC_ST_BLANK; // R13
				end
			end
			default: begin
				next_state = SCC_ST_OFF;
			end
		endcase
		if (!run) begin
			next_state = SCC_ST_OFF;
		end
	end

	// Sequence registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state       <= SCC_ST_OFF;
			timer       <= '0;
			fast_len    <= '0;
			dyn_share   <= scc_pkg::DYN_SHARE_RESET;
			slow_extend <= 1'b0;
		end else if (clk_en) begin
			state       <= next_state;
			timer       <= next_timer;
			fast_len    <= next_fast_len;
			dyn_share   <= next_dyn_share;
			slow_extend <= next_slow_extend;
		end
	end

	// Overshoot: trip already seen when blanking ends
	always_ff @(posedge clk) begin
		if (!nrst) begin
			overshoot <= 1'b0;
		end else if (clk_en) begin
			if (state == SCC_ST_BLANK && blank_end) begin
				overshoot <= trip_cmp; // R11
			end
		end
	end

	// Step direction from the target magnitude; falling step is one-shot
	always_ff @(posedge clk) begin
		if (!nrst) begin
			last_level   <= 8'h00;
			step_inc     <= 1'b1;
			fall_pending <= 1'b0;
		end else if (clk_en) begin
			last_level <= trip_current_level;
			if (level_up) begin
				step_inc <= 1'b1; // R18
			end else if (level_down) begin
				step_inc <= 1'b0;
			end
			// New falling step wins over the consuming decay entry
			if (level_down) begin
				fall_pending <= 1'b1; // R12
			end else if (state == SCC_ST_DRIVE && trip_cmp) begin
				fall_pending <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Configuration deglitch
	// ------------------------------------------------------------------
	// A setting must hold steady for the full window before it applies
	always_ff @(posedge clk) begin
		if (!nrst) begin
			scheme_cand  <= scc_pkg::SCC_DYNAMIC;
			scheme_app   <= scc_pkg::SCC_DYNAMIC;
			dg_decay_cnt <= '0;
		end else if (clk_en) begin
			if (scheme_raw != scheme_cand) begin
				scheme_cand  <= scheme_raw;
				dg_decay_cnt <= '0;
			end else if (scheme_cand != scheme_app) begin
				if (dg_decay_cnt >= scc_pkg::DEGLITCH_CYC - scc_pkg::TW'(1)) begin
					scheme_app   <= scheme_cand; // R05
					dg_decay_cnt <= '0;
				end else begin
					dg_decay_cnt <= dg_decay_cnt + scc_pkg::TW'(1);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			off_time_select_cand   <= scc_pkg::PIN_LOW;
			off_time_select_app    <= scc_pkg::PIN_LOW;
			dg_off_time_select_cnt <= '0;
		end else if (clk_en) begin
			if (off_time_select != off_time_select_cand) begin
				off_time_select_cand   <= off_time_select;
				dg_off_time_select_cnt <= '0;
			end else if (off_time_select_cand != off_time_select_app) begin
				if (dg_off_time_select_cnt >= scc_pkg::DEGLITCH_CYC - scc_pkg::TW'(1)) begin
					off_time_select_app    <= off_time_select_cand; // R16
					dg_off_time_select_cnt <= '0;
				end else begin
					dg_off_time_select_cnt <= dg_off_time_select_cnt + scc_pkg::TW'(1);
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Bridge gates and ripple setting
	// ------------------------------------------------------------------
	// Registered so no gate glitches on state decode
	always_ff @(posedge clk) begin
		if (!nrst) begin
			hs_a                 <= 1'b0;
			ls_a                 <= 1'b0;
			hs_b                 <= 1'b0;
			ls_b                 <= 1'b0;
			valley_current_level <= scc_pkg::PIN_LOW;
		end else if (clk_en) begin
			valley_current_level <= off_time_select_app; // R14
			case (next_state)
				SCC_ST_BLANK, SCC_ST_DRIVE: begin
					hs_a <= winding_dir;
					ls_b <= winding_dir;
					hs_b <= !winding_dir;
					ls_a <= !winding_dir;
				end
				SCC_ST_FAST: begin
					hs_a <= !winding_dir; // R02
					ls_b <= !winding_dir;
					hs_b <= winding_dir;
					ls_a <= winding_dir;
				end
				SCC_ST_SLOW, SCC_ST_VALLEY: begin
					hs_a <= 1'b0; // R03
					hs_b <= 1'b0;
					ls_a <= 1'b1;
					ls_b <= 1'b1;
				end
				default: begin
					hs_a <= 1'b0;
					hs_b <= 1'b0;
					ls_a <= 1'b0;
					ls_b <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Avalon-MM slave
	// ------------------------------------------------------------------
	// One wait cycle per access so read data can come from a flop
	assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

	wire logic [31:0] status_word = {16'h0000, 5'h00, dyn_share,
		1'b0, step_inc, scheme_app, state};

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl         <= scc_pkg::CTRL_RESET;
			bus_ack      <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else if (clk_en) begin
			bus_ack <= (avs_read || avs_write) && !bus_ack;
			// Write lands at the edge that ends the wait, as the master sees it
			if (avs_write && bus_ack && avs_address == scc_pkg::REG_CTRL) begin
				ctrl <= avs_writedata[1:0];
			end
			if (avs_read && !bus_ack) begin
				case (avs_address)
					scc_pkg::REG_CTRL:   avs_readdata <= {30'h0, ctrl};
					scc_pkg::REG_STATUS: avs_readdata <= status_word;
					default:             avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

/* File: scc_chopper_asserts.sv */
module scc_chopper_asserts (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [1:0] off_time_select,
	input  wire logic       trip_cmp,
	input  wire logic       hs_a,
	input  wire logic       ls_a,
	input  wire logic       hs_b,
	input  wire logic       ls_b,
	input  wire logic [1:0] valley_current_level
);
	// ------------------------------------------------------------------
	// Gate patterns, for a winding driven with hs_a and ls_b
	// ------------------------------------------------------------------
	wire        drv = hs_a & ls_b & !hs_b & !ls_a;
	wire        fst = hs_b & ls_a & !hs_a & !ls_b;
	wire        slw = ls_a & ls_b & !hs_a & !hs_b;
	logic [9:0] dcnt;
	logic [9:0] scnt;
	logic [1:0] ots_q;

	// Drive run length, and how long the off-time pin has held still
	always_ff @(posedge clk) begin
		dcnt  <= (!nrst || !drv) ? 10'h0 : dcnt + 10'h1;
		ots_q <= off_time_select;
		scnt  <= (!nrst || ots_q != off_time_select) ? 10'h0 :
			(scnt == 10'h3ff) ? scnt : scnt + 10'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_reset_gates: assert property ($rose(nrst) |->
		!(hs_a | ls_a | hs_b | ls_b)) else $error("gates on after reset");
	chk_no_short: assert property (!(hs_a & ls_a) && !(hs_b & ls_b))
		else $error("bridge leg shorted");
	chk_blank_ignore: assert property (
		drv && dcnt < 10'h18 && trip_cmp |=> drv)
		else $error("trip taken during blanking");
	chk_blank_min: assert property (!drv && $past(drv) |->
		$past(dcnt) >= 10'h18) else $error("drive shorter than blanking");
	chk_drive_trip: assert property (
		drv && dcnt >= 10'h1a && trip_cmp |=> !drv)
		else $error("drive kept after trip");
	chk_fast_after: assert property ($rose(fst) |-> $past(drv))
		else $error("fast decay not after drive");
	chk_slow_after: assert property ($rose(slw) |->
		$past(drv) || $past(fst)) else $error("slow decay out of order");
	chk_fast_exit: assert property ($fell(fst) |-> slw || drv)
		else $error("fast decay left badly");
	chk_off_time_select_glitch: assert property (
		$changed(valley_current_level) |->
		valley_current_level == $past(off_time_select) && scnt >= 10'hf0)
		else $error("off-time applied before deglitch");
endmodule

bind scc_chopper scc_chopper_asserts u_chk (.clk, .nrst, .off_time_select,
	.trip_cmp, .hs_a, .ls_a, .hs_b, .ls_b, .valley_current_level);

/* File: scc_pkg.sv */
package scc_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ      = 25;
	localparam int DEGLITCH_NS  = 10000;
	localparam int BLANK_NS     = 1000;
	localparam int OFF_TIME_SELECT_0_NS    = 7000;
	localparam int OFF_TIME_SELECT_1_NS    = 16000;
	localparam int OFF_TIME_SELECT_Z_NS    = 24000;
	localparam int OFF_TIME_SELECT_R_NS    = 32000;

	// Least times round up to whole cycles
	function automatic int ns_to_cyc(input int ns);
		return (ns * CLK_MHZ + 999) / 1000;
	endfunction

	localparam int TW = 10;
	localparam logic [TW-1:0] DEGLITCH_CYC = TW'(ns_to_cyc(DEGLITCH_NS));
	localparam logic [TW-1:0] BLANK_CYC    = TW'(ns_to_cyc(BLANK_NS));
	localparam logic [TW-1:0] OFF_TIME_SELECT_0_CYC   = TW'(ns_to_cyc(OFF_TIME_SELECT_0_NS));
	localparam logic [TW-1:0] OFF_TIME_SELECT_1_CYC   = TW'(ns_to_cyc(OFF_TIME_SELECT_1_NS));
	localparam logic [TW-1:0] OFF_TIME_SELECT_Z_CYC   = TW'(ns_to_cyc(OFF_TIME_SELECT_Z_NS));
	localparam logic [TW-1:0] OFF_TIME_SELECT_R_CYC   = TW'(ns_to_cyc(OFF_TIME_SELECT_R_NS));

	// ------------------------------------------------------------------
	// Decoded multi-level pin codes
	// ------------------------------------------------------------------
	localparam logic [1:0] PIN_LOW  = 2'h0;
	localparam logic [1:0] PIN_HIGH = 2'h1;
	localparam logic [1:0] PIN_HIZ  = 2'h2;
	localparam logic [1:0] PIN_RES  = 2'h3;

	// Fast share of the decay interval, in percent; dynamic share limits in PCT_DYN_STEP steps
	localparam logic [6:0] PCT_MIX30   = 7'h1e;
	localparam logic [6:0] PCT_MIX60   = 7'h3c;
	localparam logic [6:0] PCT_FULL    = 7'h64;
	localparam logic [6:0] PCT_DYN_STEP = 7'h0c;
	localparam logic [2:0] DYN_SHARE_MAX   = 3'h7;
	localparam logic [2:0] DYN_SHARE_RESET = 3'h2;

	typedef enum logic [2:0] {
		SCC_DYNAMIC,
		SCC_RIPPLE,
		SCC_MIX30,
		SCC_SLOWMIX,
		SCC_MIX60,
		SCC_SLOW
	} scc_scheme_e;

	// ------------------------------------------------------------------
	// Register map (word addresses, word index on the bus)
	// ------------------------------------------------------------------
	localparam logic [1:0] REG_CTRL   = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_COARSE = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

endpackage

/* File: tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        clk_en = 1'b1;
	logic        winding_dir = 1'b1;
	logic        stall = 1'b0;
	logic [1:0]  decay_select_a = 2'h0;
	logic [1:0]  decay_select_b = 2'h0;
	logic [1:0]  off_time_select = 2'h0;
	logic [7:0]  trip_current_level = 8'h64;
	logic        trip_cmp, valley_cmp, hs_a, ls_a, hs_b, ls_b;
	logic [1:0]  valley_current_level;
	logic [1:0]  avs_address = 2'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic        avs_waitrequest;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, q;
	int          error_cnt = 0;
	int          n_checks = 0;
	int          n;
	logic [1:0]  ta [7] = '{2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
	logic [1:0]  tb [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h1};
	logic [2:0]  es [7] = '{3'h2, 3'h0, 3'h1, 3'h3, 3'h4, 3'h0, 3'h5};
	int          tns [4] = '{7000, 16000, 24000, 32000};

	scc_chopper DUT (.clk, .nrst, .clk_en, .decay_select_a,
		.decay_select_b, .off_time_select, .trip_current_level,
		.winding_dir, .trip_cmp, .valley_cmp, .hs_a, .ls_a, .hs_b,
		.ls_b, .valley_current_level, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
	scc_bridge_model u_bridge (.clk, .hs_a, .ls_a, .hs_b, .ls_b,
		.trip_level(trip_current_level), .stall, .trip_cmp, .valley_cmp);

	always #20 clk = ~clk;

	// ------------------------------------------------------------------
	// Checking, bus and waiting tasks
	// ------------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until an edge that sees waitrequest low
	task automatic bus(input logic w, input logic [1:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk);
		avs_write     <= w;
		avs_read      <= !w;
		avs_address   <= a;
		avs_writedata <= d;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (avs_waitrequest && i < 50);
		if (avs_waitrequest) begin
			error_cnt++;
			stop_test();
		end
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	function automatic logic pat(input int k);
		if (k == 0)
			return ls_a & ls_b & !hs_a & !hs_b;
		return hs_b & ls_a & !hs_a & !ls_b;
	endfunction

	// Skips a run in progress, so only whole runs are measured
	task automatic run_len(input int k, input bit cnt);
		int i;
		i = 0;
		n = 0;
		while (pat(k) && i < 9000) begin
			@(negedge clk);
			i++;
		end
		while (!pat(k) && i < 9000) begin
			@(negedge clk);
			i++;
		end
		while (cnt && pat(k) && n < 9000) begin
			@(negedge clk);
			n++;
		end
		if (i >= 9000) begin
			error_cnt++;
			stop_test();
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		cyc(12);
		nrst <= 1'b1;
		bus(0, scc_pkg::REG_CTRL, 0);
		chk(q, 32'h0);
		bus(0, 2'h2, 0);
		chk(q, 32'h0);
		bus(1, scc_pkg::REG_CTRL, 32'h2);
		bus(0, scc_pkg::REG_CTRL, 0);
		chk(q, 32'h2);
		for (int k = 0; k < 7; k++) begin
			decay_select_a <= ta[k];
			decay_select_b <= tb[k];
			cyc(100);
			bus(0, scc_pkg::REG_STATUS, 0);
			chk(32'(q[5:3]), 32'(k ? es[k - 1] : 3'h0));
			cyc(200);
			bus(0, scc_pkg::REG_STATUS, 0);
			chk(32'(q[5:3]), 32'(es[k]));
		end
		bus(1, scc_pkg::REG_CTRL, 32'h1);
		for (int k = 0; k < 4; k++) begin
			off_time_select <= 2'(k);
			cyc(300);
			chk(32'(valley_current_level), k);
			run_len(0, 1);
			chk(n, tns[k] / 40);
		end
		off_time_select <= 2'h0;
		cyc(300);
		run_len(0, 0);
		stall <= 1'b1;
		// Measure the run that has just begun, stalled from its start
		fork
			begin
				n = 0;
				while (pat(0) && n < 9000) begin
					@(negedge clk);
					n++;
				end
			end
			begin
				cyc(300);
				stall <= 1'b0;
			end
		join
		chk(n, 350);
		for (int k = 0; k < 2; k++) begin
			decay_select_a <= 2'(k + 1);
			decay_select_b <= 2'h0;
			cyc(300);
			run_len(1, 1);
			chk(n, k ? 105 : 52);
			run_len(0, 1);
			chk(n, k ? 70 : 123);
		end
		decay_select_a <= 2'h0;
		decay_select_b <= 2'h1;
		cyc(300);
		run_len(0, 0);
		bus(0, scc_pkg::REG_STATUS, 0);
		chk(32'(q[2:0]), 32'h5);
		decay_select_a <= 2'h1;
		cyc(300);
		trip_current_level <= 8'h78;
		bus(0, scc_pkg::REG_STATUS, 0);
		chk(32'(q[6]), 32'h1);
		run_len(0, 1);
		chk(n, 175);
		trip_current_level <= 8'h64;
		run_len(1, 1);
		chk(n, 52);
		bus(1, scc_pkg::REG_CTRL, 32'h3);
		trip_current_level <= 8'h78;
		run_len(1, 1);
		chk(n, 52);
		decay_select_a <= 2'h0;
		decay_select_b <= 2'h0;
		cyc(300);
		trip_current_level <= 8'h50;
		run_len(1, 1);
		chk(n, 175);
		stop_test();
	end
endmodule
